// ===== verification/handshake_parallel_io_assertions.sv
`timescale 1ns/1ps
module handshake_parallel_io_assertions
    import hsio_pkg::*;
#(
    parameter int DW = DATA_WIDTH
) (
    input wire logic                    MCLK,
    input wire logic                    RESET,
    input wire logic                    ENABLE,
    input wire mode_type                MODE,
    input wire logic                    DIR_OUT,
    input wire logic                    ACK_LOW,
    input wire logic                    REQ_LOW,
    input wire logic [DELAY_CODE_W-1:0] DELAY,
    input wire logic                    ack,
    input wire logic                    req,
    input wire logic [DW-1:0]           dev_d
);
    logic       emul;
    logic       level;
    logic       ack_act;
    logic       req_act;
    logic       seen_q;
    logic [7:0] ack_cnt_q;
    logic [7:0] trail_min;
    logic [7:0] trail_max;
    logic [7:0] lead_min;

    assign emul      = (MODE == MODE_EMUL);
    assign level     = (MODE == MODE_LEVEL);
    assign ack_act   = ack ^ (emul | ACK_LOW);
    assign req_act   = req ^ (emul | REQ_LOW);
    assign trail_min = 8'((TRAIL_PULSE_MIN_NS + DELAY_STEP_NS * int'(DELAY) + CLK_NS - 1) / CLK_NS);
    assign trail_max = 8'((TRAIL_PULSE_MAX_NS + DELAY_STEP_NS * int'(DELAY)) / CLK_NS);
    assign lead_min  = 8'(LEAD_PULSE_CYC + ((MODE == MODE_LONG) ? DELAY_STEP_CYC * int'(DELAY) : 0));

    // Length of the acknowledge pulse in progress, saturating
    always_ff @(posedge MCLK) begin
        if (RESET || !ack_act) begin
            ack_cnt_q <= 8'h00;
        end else if (ack_cnt_q != 8'hFF) begin
            ack_cnt_q <= ack_cnt_q + 8'h01;
        end
    end

    // Set before the design's synchroniser can see it, so the check never fires early
    always_ff @(posedge MCLK) begin
        if (RESET || !ENABLE) begin
            seen_q <= 1'b0;
        end else if (req_act) begin
            seen_q <= 1'b1;
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);

    AST_ACK_IDLE: assert property (
        (!ENABLE && $stable(MODE) && $stable(ACK_LOW)) [*3] |-> !ack_act)
        else $error("acknowledge not at its idle level while disabled");
    AST_ACK_HOLD: assert property (
        (ENABLE && level && ack_act && !req_act) [*4] |=> ack_act)
        else $error("acknowledge dropped without a request edge");
    AST_ACK_DROP: assert property (
        ENABLE && (level || (emul && DIR_OUT)) && ack_act && $rose(req_act)
        |-> ##[1:5] !ack_act)
        else $error("acknowledge held after a request edge");
    AST_EMUL_WAIT_REL: assert property (
        ENABLE && emul && DIR_OUT && req_act && !ack_act |=> !ack_act)
        else $error("acknowledge returned while request still active");
    AST_TRAIL_WIDTH: assert property (
        $past(ENABLE) && MODE == MODE_TRAIL && !DIR_OUT && $fell(ack_act)
        |-> ack_cnt_q >= trail_min && ack_cnt_q <= trail_max)
        else $error("trailing edge acknowledge pulse width out of range");
    AST_PULSE_MIN: assert property (
        $past(ENABLE) && (MODE == MODE_LEAD || MODE == MODE_LONG) && $fell(ack_act)
        |-> ack_cnt_q >= lead_min)
        else $error("acknowledge pulse shorter than required");
    AST_DATA_FIRST: assert property (
        ENABLE && DIR_OUT && (level || emul) && ack_act |-> $stable(dev_d))
        else $error("output data moved while acknowledge active");
    AST_LEVEL_ARM: assert property (
        ENABLE && level && !DIR_OUT && !seen_q |-> !ack_act)
        else $error("acknowledge before any request since enable");
endmodule

// ===== verification/test_handshake_parallel_io.sv
`timescale 1ns/1ps
module test_handshake_parallel_io
    import hsio_pkg::*;
;
    logic                    mclk;
    logic                    reset;
    logic                    enable;
    mode_type                mode;
    logic                    dir_out;
    logic                    ack_low;
    logic                    req_low;
    logic                    latch_swap;
    logic [DELAY_CODE_W-1:0] delay;
    logic [DATA_WIDTH-1:0]   tx_data;
    logic                    tx_valid;
    logic                    tx_ready;
    logic [DATA_WIDTH-1:0]   rx_data;
    logic                    rx_valid;
    logic                    rx_ready;
    logic [DATA_WIDTH-1:0]   send_data;
    logic                    send_valid;
    logic                    send_ready;
    logic [DATA_WIDTH-1:0]   recv_data;
    logic                    recv_valid;
    logic [DATA_WIDTH-1:0]   got_q[$];
    int                      err_count;
    int                      total_checks;
    mode_type                mode_list[5];

    hsio_if #(.DW(DATA_WIDTH)) lnk ();

    handshake_device #(.DW(DATA_WIDTH)) u_handshake_device (
        .MCLK(mclk), .RESET(reset), .LINK(lnk), .ENABLE(enable), .MODE(mode),
        .DIR_OUT(dir_out), .ACK_LOW(ack_low), .REQ_LOW(req_low), .LATCH_SWAP(latch_swap),
        .DELAY(delay), .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready),
        .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_READY(rx_ready));

    handshake_peripheral #(.DW(DATA_WIDTH)) u_handshake_peripheral (
        .MCLK(mclk), .RESET(reset), .LINK(lnk), .ENABLE(enable), .MODE(mode),
        .DIR_OUT(dir_out), .ACK_LOW(ack_low), .REQ_LOW(req_low), .SEND_DATA(send_data),
        .SEND_VALID(send_valid), .SEND_READY(send_ready), .RECV_DATA(recv_data),
        .RECV_VALID(recv_valid));

    handshake_parallel_io_assertions #(.DW(DATA_WIDTH)) u_handshake_parallel_io_assertions (
        .MCLK(mclk), .RESET(reset), .ENABLE(enable), .MODE(mode), .DIR_OUT(dir_out),
        .ACK_LOW(ack_low), .REQ_LOW(req_low), .DELAY(delay), .ack(lnk.ack), .req(lnk.req),
        .dev_d(lnk.dev_d));

    initial begin
        mclk = 1'b0;
    end
    always #25 mclk = ~mclk;

    // Words delivered at either user side, in arrival order
    always @(posedge mclk) begin
        if (recv_valid === 1'b1) got_q.push_back(recv_data);
        if (rx_valid === 1'b1 && rx_ready === 1'b1) got_q.push_back(rx_data);
    end

    task automatic check(input string name, input logic [DATA_WIDTH-1:0] seen,
                         input logic [DATA_WIDTH-1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Odd words inverted so every data line above bit 1 toggles between transfers
    function automatic logic [DATA_WIDTH-1:0] word_of(input int idx, input int k);
        logic [DATA_WIDTH-1:0] v;
        v = DATA_WIDTH'(32'hA5C30000 + idx * 256 + k);
        return (k % 2 == 1) ? ~v : v;
    endfunction

    // Offers one word on the sending user side and holds it until taken
    task automatic put_word(input logic [DATA_WIDTH-1:0] w);
        int n;
        @(posedge mclk);
        if (dir_out) begin
            tx_data  <= w;
            tx_valid <= 1'b1;
        end else begin
            send_data  <= w;
            send_valid <= 1'b1;
        end
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while ((dir_out ? tx_ready : send_ready) !== 1'b1 && n < 1000);
        tx_valid   <= 1'b0;
        send_valid <= 1'b0;
    endtask

    // One mode and direction: idle levels, then three words end to end
    task automatic run_case(input int idx);
        int   n;
        logic ack_idle;
        logic req_idle;
        @(posedge mclk);
        enable     <= 1'b0;
        mode       <= mode_list[idx / 2];
        dir_out    <= (idx % 2 == 1);
        ack_low    <= (idx % 3 == 0);
        req_low    <= (idx % 4 < 2);
        latch_swap <= (idx == 3 || idx == 8);
        delay      <= DELAY_CODE_W'((7 - idx) % 8);
        repeat (4) @(posedge mclk);
        ack_idle = (mode == MODE_EMUL) | ack_low;
        req_idle = (mode == MODE_EMUL) | req_low;
        check("ack idle level", DATA_WIDTH'(lnk.ack), DATA_WIDTH'(ack_idle));
        check("req idle level", DATA_WIDTH'(lnk.req), DATA_WIDTH'(req_idle));
        got_q.delete();
        enable   <= 1'b1;
        rx_ready <= (idx != 2);
        fork
            begin
                for (int k = 0; k < 3; k++) put_word(word_of(idx, k));
            end
        join_none
        if (idx == 2) begin
            // Receiver stalls: the full buffer must keep the link quiet
            repeat (40) @(posedge mclk);
            check("rx held", DATA_WIDTH'(rx_valid), DATA_WIDTH'(1'b1));
            check("rx first word", rx_data, word_of(idx, 0));
            check("ack while full", DATA_WIDTH'(lnk.ack), DATA_WIDTH'(ack_idle));
            rx_ready <= 1'b1;
        end
        n = 0;
        while (got_q.size() < 3 && n < 2000) begin
            @(posedge mclk);
            n++;
        end
        for (int k = 0; k < 3; k++) begin
            check("word", got_q[k], word_of(idx, k));
        end
        repeat (5) @(posedge mclk);
    endtask

    initial begin
        err_count    = 0;
        total_checks = 0;
        reset        = 1'b1;
        enable       = 1'b0;
        mode         = MODE_EMUL;
        dir_out      = 1'b0;
        ack_low      = 1'b0;
        req_low      = 1'b0;
        latch_swap   = 1'b0;
        delay        = 3'h0;
        tx_data      = 32'h00000000;
        tx_valid     = 1'b0;
        rx_ready     = 1'b1;
        send_data    = 32'h00000000;
        send_valid   = 1'b0;
        mode_list    = '{MODE_EMUL, MODE_LEVEL, MODE_LEAD, MODE_TRAIL, MODE_LONG};
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        for (int i = 0; i < 10; i++) run_case(i);
        wrap_up();
    end

    // Ten cases of under two hundred cycles each; this leaves ample margin
    initial begin
        repeat (40000) @(posedge mclk);
        err_count++;
        wrap_up();
    end
endmodule

// ===== verilog/handshake_device.sv
// Operation
// - Emulation mode: both lines fixed active low
// - Other modes: separate acknowledge and request polarity
// - Emulation input: request strobes, acknowledge shows full
// - Emulation output: acknowledge shows output buffer full
// - Emulation output: assert acknowledge, await request
// - Emulation output: request edge drops acknowledge
// - Emulation output: next transfer after request release
// - Peripheral holds request until data captured
// - Emulation output: reassert acknowledge after optional delay
// - Configurable settling delay between consecutive transfers
// - Level mode: acknowledge held until request edge
// - Level input: nothing before peripheral asserts request
// - Level input: acknowledge only with buffer space
// - Level input: request edge drops acknowledge, captures
// - Level output: data first, then acknowledge
// - Level output: held request needs fresh edge
// - Input: request latching default on, else acknowledge
// - Output: latching default off, else update on release
// - Trailing-edge mode: pulse trailing edge means ready
// - Leading-edge mode: pulse leading edge means ready
// - Long-pulse mode: delay stretches the acknowledge pulse
// - Delay zero to 700 ns in 100 ns steps
`timescale 1ns/1ps
module handshake_device
    import hsio_pkg::*;
#(
    parameter int DW = DATA_WIDTH
) (
    input  wire logic                    MCLK,
    input  wire logic                    RESET,
    hsio_if.dev                          LINK,
    input  wire logic                    ENABLE,
    input  wire mode_type                MODE,
    input  wire logic                    DIR_OUT,
    input  wire logic                    ACK_LOW,
    input  wire logic                    REQ_LOW,
    input  wire logic                    LATCH_SWAP,
    input  wire logic [DELAY_CODE_W-1:0] DELAY,
    input  wire logic [DW-1:0]           TX_DATA,
    input  wire logic                    TX_VALID,
    output logic                         TX_READY,
    output logic [DW-1:0]                RX_DATA,
    output logic                         RX_VALID,
    input  wire logic                    RX_READY
);

    if (DW < 1 || DW != $bits(LINK.data))
        $error("Data width must be positive and match the link");
    if (TRAIL_PULSE_CYC > TRAIL_PULSE_MAX_CYC)
        $error("Clock too slow for the trailing-edge pulse window");
    if (TRAIL_PULSE_CYC + DELAY_STEP_CYC * ((1 << DELAY_CODE_W) - 1) >= (1 << CNT_W))
        $error("Counter too narrow for pulse plus delay");

    dev_state_type    state_q;
    dev_state_type    state_d;
    logic             req_s1_q;
    logic             req_s2_q;
    logic [DW-1:0]    data_s1_q;
    logic [DW-1:0]    data_s2_q;
    logic             req_act;
    logic             req_act_q;
    logic             req_rise;
    logic             req_fall;
    logic             xfer_edge;
    logic             emul;
    logic             emul_in;
    logic             pulse_mode;
    logic             stretch_mode;
    logic             latch_en;
    logic             ready;
    logic             start;
    logic             ack_on;
    logic             ack_act;
    logic             xfer;
    logic             armed_q;
    logic             got_q;
    logic             pend_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] delay_cyc;
    logic [CNT_W-1:0] pre_delay;
    logic [CNT_W-1:0] pulse_len;
    logic [DW-1:0]    tx_word_q;
    logic             tx_full_q;
    logic [DW-1:0]    dout_q;
    logic             rx_full_q;
    logic [DW-1:0]    rx_word_q;

    assign emul         = (MODE == MODE_EMUL);
    assign emul_in      = emul && !DIR_OUT;
    assign pulse_mode   = (MODE == MODE_TRAIL) || (MODE == MODE_LEAD) || (MODE == MODE_LONG);
    assign stretch_mode = (MODE == MODE_LEAD) || (MODE == MODE_LONG);
    // Zero on the swap input gives the usual latching per direction
    assign latch_en     = DIR_OUT ? LATCH_SWAP : !LATCH_SWAP;

    // Pin sampling: data is staged with request so both align
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            req_s1_q  <= 1'b0;
            req_s2_q  <= 1'b0;
            data_s1_q <= '0;
            data_s2_q <= '0;
        end else begin
            req_s1_q  <= LINK.req;
            req_s2_q  <= req_s1_q;
            data_s1_q <= LINK.data;
            data_s2_q <= data_s1_q;
        end
    end

    assign req_act = req_s2_q ^ (emul | REQ_LOW);

    // Starts as active so a request already held at reset is no edge
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            req_act_q <= 1'b1;
        end else begin
            req_act_q <= req_act;
        end
    end

    assign req_rise  = req_act && !req_act_q;
    assign req_fall  = !req_act && req_act_q;
    assign xfer_edge = (MODE == MODE_TRAIL) ? req_fall : req_rise;

    assign delay_cyc = CNT_W'(DELAY) * CNT_W'(DELAY_STEP_CYC);
    // Delay sits before acknowledge except where it lengthens the pulse
    assign pre_delay = (MODE == MODE_TRAIL || MODE == MODE_LONG) ? CNT_ZERO : delay_cyc;

    always_comb begin
        case (MODE)
            MODE_TRAIL: pulse_len = CNT_W'(TRAIL_PULSE_CYC - 1) + delay_cyc;
            MODE_LONG:  pulse_len = CNT_W'(LEAD_PULSE_CYC - 1) + delay_cyc;
            default:    pulse_len = CNT_W'(LEAD_PULSE_CYC - 1);
        endcase
    end

    // Output loads only with the far side released when latching
    assign ready = DIR_OUT ? (tx_full_q && (!latch_en || !req_act))
                           : (!rx_full_q && armed_q);
    assign start  = (state_q == D_IDLE) && ENABLE && !emul_in && ready;
    assign ack_on = (state_q == D_DELAY) && (cnt_q == CNT_ZERO);

    always_comb begin
        if (emul_in) begin
            xfer = ENABLE && req_rise && !rx_full_q;
        end else if (pulse_mode) begin
            xfer = (state_q == D_ACK || state_q == D_WAIT) && xfer_edge && !got_q;
        end else begin
            xfer = (state_q == D_ACK) && req_rise;
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            D_IDLE: begin
                if (start) begin
                    state_d = D_DELAY;
                end
            end
            D_DELAY: begin
                if (ack_on) begin
                    state_d = D_ACK;
                end
            end
            D_ACK: begin
                if (!pulse_mode) begin
                    if (xfer) begin
                        state_d = emul ? D_REL : D_IDLE;
                    end
                end else if (cnt_q == CNT_ZERO && !(stretch_mode && req_act)) begin
                    state_d = (got_q || xfer) ? D_IDLE : D_WAIT;
                end
            end
            D_WAIT: begin
                if (xfer) begin
                    state_d = D_IDLE;
                end
            end
            D_REL: begin
                if (!req_act) begin
                    state_d = D_IDLE;
                end
            end
            default: state_d = D_IDLE;
        endcase
        if (!ENABLE) begin
            state_d = D_IDLE;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            state_q <= D_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            cnt_q <= CNT_ZERO;
        end else if (start) begin
            cnt_q <= pre_delay;
        end else if (ack_on) begin
            cnt_q <= pulse_len;
        end else if (cnt_q != CNT_ZERO) begin
            cnt_q <= cnt_q - 5'h01;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            got_q <= 1'b0;
        end else if (ack_on) begin
            got_q <= 1'b0;
        end else if (xfer) begin
            got_q <= 1'b1;
        end
    end

    // No acknowledge until the peripheral has shown a request
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            armed_q <= 1'b0;
        end else if (!ENABLE || DIR_OUT) begin
            armed_q <= 1'b0;
        end else if (req_act) begin
            armed_q <= 1'b1;
        end
    end

    // Input side: one word of buffer; a fresh word wins over a read
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            pend_q    <= 1'b0;
            rx_full_q <= 1'b0;
            rx_word_q <= '0;
        end else if (!ENABLE && pend_q) begin
            pend_q <= 1'b0; // Stale word must not surface after re-enable
        end else if (xfer && !DIR_OUT && (latch_en || emul)) begin
            rx_full_q <= 1'b1;
            rx_word_q <= data_s2_q;
        end else if (xfer && !DIR_OUT) begin
            pend_q <= 1'b1;
        end else if (ack_on && pend_q) begin
            pend_q    <= 1'b0;
            rx_full_q <= 1'b1;
            rx_word_q <= data_s2_q;
        end else if (rx_full_q && RX_READY) begin
            rx_full_q <= 1'b0;
        end
    end

    // Output side: holding word moves to the pins before acknowledge
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            tx_full_q <= 1'b0;
            tx_word_q <= '0;
            dout_q    <= '0;
        end else if (start && DIR_OUT) begin
            tx_full_q <= 1'b0;
            dout_q    <= tx_word_q;
        end else if (TX_VALID && !tx_full_q) begin
            tx_full_q <= 1'b1;
            tx_word_q <= TX_DATA;
        end
    end

    assign ack_act     = emul_in ? rx_full_q : (state_q == D_ACK);
    assign LINK.ack    = ack_act ^ (emul | ACK_LOW);
    assign LINK.dev_d  = dout_q;
    assign LINK.dev_oe = DIR_OUT && ENABLE;
    assign TX_READY    = !tx_full_q;
    assign RX_VALID    = rx_full_q;
    assign RX_DATA     = rx_word_q;

endmodule

// ===== verilog/handshake_peripheral.sv
`timescale 1ns/1ps
module handshake_peripheral
    import hsio_pkg::*;
#(
    parameter int DW = DATA_WIDTH
) (
    input  wire logic          MCLK,
    input  wire logic          RESET,
    hsio_if.per                LINK,
    input  wire logic          ENABLE,
    input  wire mode_type      MODE,
    input  wire logic          DIR_OUT,
    input  wire logic          ACK_LOW,
    input  wire logic          REQ_LOW,
    input  wire logic [DW-1:0] SEND_DATA,
    input  wire logic          SEND_VALID,
    output logic               SEND_READY,
    output logic [DW-1:0]      RECV_DATA,
    output logic               RECV_VALID
);

    if (DW < 1 || DW != $bits(LINK.data))
        $error("Data width must be positive and match the link");

    per_state_type    state_q;
    per_state_type    state_d;
    logic             ack_s1_q;
    logic             ack_s2_q;
    logic [DW-1:0]    data_s1_q;
    logic [DW-1:0]    data_s2_q;
    logic             ack_act;
    logic             ack_act_q;
    logic             ack_edge;
    logic             seen_q;
    logic             emul;
    logic             go;
    logic             req_act;
    logic [CNT_W-1:0] cnt_q;
    logic [DW-1:0]    send_q;
    logic [DW-1:0]    recv_q;
    logic             recv_v_q;

    assign emul = (MODE == MODE_EMUL);

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            ack_s1_q  <= 1'b0;
            ack_s2_q  <= 1'b0;
            data_s1_q <= '0;
            data_s2_q <= '0;
        end else begin
            ack_s1_q  <= LINK.ack;
            ack_s2_q  <= ack_s1_q;
            data_s1_q <= LINK.data;
            data_s2_q <= data_s1_q;
        end
    end

    assign ack_act = ack_s2_q ^ (emul | ACK_LOW);

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            ack_act_q <= 1'b1;
        end else begin
            ack_act_q <= ack_act;
        end
    end

    // Trailing mode reads readiness from the end of the acknowledge pulse
    assign ack_edge = (MODE == MODE_TRAIL) ? (!ack_act && ack_act_q) : (ack_act && !ack_act_q);

    // Edge modes only move on a fresh acknowledge; disabled clears first so
    // polarity changes while idle leave no false edge behind
    always_ff @(posedge MCLK) begin
        if (RESET || !ENABLE) begin
            seen_q <= 1'b0;
        end else if (ack_edge) begin
            seen_q <= 1'b1;
        end else if (go) begin
            seen_q <= 1'b0;
        end
    end

    // Emulation reacts to acknowledge level: full blocks, ready invites
    always_comb begin
        if (DIR_OUT) begin
            go = emul ? ack_act : seen_q;
        end else begin
            go = SEND_VALID && (emul ? !ack_act : seen_q);
        end
        go = go && ENABLE && (state_q == P_IDLE);
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            P_ARM: begin
                if (ENABLE && (DIR_OUT || emul || cnt_q == CNT_ZERO)) begin
                    state_d = P_GAP;
                end
            end
            P_GAP: begin
                if (cnt_q == CNT_ZERO) begin
                    state_d = P_IDLE;
                end
            end
            P_IDLE: begin
                if (go) begin
                    state_d = P_PULSE;
                end
            end
            P_PULSE: begin
                if (cnt_q == CNT_ZERO && !(emul && DIR_OUT && ack_act)) begin
                    state_d = P_GAP;
                end
            end
            default: state_d = P_ARM;
        endcase
        if (!ENABLE) begin
            state_d = P_ARM;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            state_q <= P_ARM;
        end else begin
            state_q <= state_d;
        end
    end

    // Every request pulse and gap lasts at least the minimum width; held in
    // reload while disabled so the arming pulse gets its full width too
    always_ff @(posedge MCLK) begin
        if (RESET || !ENABLE || state_q != state_d) begin
            cnt_q <= CNT_W'(REQ_WIDTH_CYC - 1);
        end else if (cnt_q != CNT_ZERO) begin
            cnt_q <= cnt_q - 5'h01;
        end
    end

    // Received data was settled before acknowledge, so take it at once
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            send_q   <= '0;
            recv_q   <= '0;
            recv_v_q <= 1'b0;
        end else begin
            recv_v_q <= go && DIR_OUT;
            if (go && DIR_OUT) begin
                recv_q <= data_s2_q;
            end
            if (go && !DIR_OUT) begin
                send_q <= SEND_DATA;
            end
        end
    end

    assign req_act     = (state_q == P_PULSE) || (state_q == P_ARM && ENABLE && !DIR_OUT && !emul);
    assign LINK.req    = req_act ^ (emul | REQ_LOW);
    assign LINK.per_d  = send_q;
    assign LINK.per_oe = !DIR_OUT && ENABLE;
    assign SEND_READY  = go && !DIR_OUT;
    assign RECV_DATA   = recv_q;
    assign RECV_VALID  = recv_v_q;

endmodule

// ===== verilog/hsio_if.sv
`timescale 1ns/1ps
interface hsio_if #(parameter int DW = hsio_pkg::DATA_WIDTH);
    logic          ack;
    logic          req;
    logic [DW-1:0] dev_d;
    logic          dev_oe;
    logic [DW-1:0] per_d;
    logic          per_oe;
    logic [DW-1:0] data;

    // Device drive wins if both ends enable at once
    assign data = dev_oe ? dev_d : (per_oe ? per_d : '0);

    modport dev (output ack, output dev_d, output dev_oe, input req, input data);
    modport per (input ack, output req, output per_d, output per_oe, input data);
endinterface

// ===== verilog/hsio_pkg.sv
package hsio_pkg;
    typedef enum logic [2:0] {
        MODE_EMUL  = 3'h0,
        MODE_LEVEL = 3'h1,
        MODE_LEAD  = 3'h2,
        MODE_TRAIL = 3'h3,
        MODE_LONG  = 3'h6
    } mode_type;

    typedef enum logic [2:0] {
        D_IDLE  = 3'h0,
        D_DELAY = 3'h1,
        D_ACK   = 3'h3,
        D_WAIT  = 3'h2,
        D_REL   = 3'h6
    } dev_state_type;

    typedef enum logic [1:0] {
        P_ARM   = 2'h0,
        P_GAP   = 2'h1,
        P_IDLE  = 2'h3,
        P_PULSE = 2'h2
    } per_state_type;

    localparam int DATA_WIDTH         = 32;
    localparam int DELAY_CODE_W       = 3;
    localparam int CNT_W              = 5;
    localparam int CLK_NS             = 50;
    localparam int DELAY_STEP_NS      = 100;
    localparam int TRAIL_PULSE_MIN_NS = 225;
    localparam int TRAIL_PULSE_MAX_NS = 275;
    localparam int LEAD_PULSE_NS      = 125;
    localparam int REQ_WIDTH_NS       = 75;

    localparam int DELAY_STEP_CYC      = (DELAY_STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int TRAIL_PULSE_CYC     = (TRAIL_PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int TRAIL_PULSE_MAX_CYC = TRAIL_PULSE_MAX_NS / CLK_NS;
    localparam int LEAD_PULSE_CYC      = (LEAD_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int REQ_WIDTH_CYC       = (REQ_WIDTH_NS + CLK_NS - 1) / CLK_NS;

    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
endpackage
